// file: src/cfa_top.sv
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "cfa_defs.svh"

module cfa_top
  import cfa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic cam_pix_clk,
  input wire logic [`CFA_DW-1:0] cam_data,
  input wire logic cam_fval,
  input wire logic cam_lval,
  input wire logic cam_dval,
  input wire logic cam_spare,
  input wire logic [3:0] front_trigger_lines_in,
  output logic [3:0] front_trigger_lines_out,
  output logic [3:0] front_trigger_lines_oe,
  input wire logic [3:0] backplane_trigger_bus_in,
  output logic [3:0] backplane_trigger_bus_out,
  output logic [3:0] backplane_trigger_bus_oe,
  output logic [`CFA_NCC-1:0] camera_control_outputs,
  output logic [`CFA_DW-1:0] pix_out_data,
  output logic pix_out_spare,
  output logic pix_out_valid,
  output logic pix_out_frame_start,
  output logic acq_done,
  output logic irq
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic cfa_in_win(input logic [`CFA_CW-1:0] idx,
                                      input logic [`CFA_CW-1:0] first,
                                      input logic [`CFA_CW-1:0] count);
    logic [`CFA_CW-1:0] rel;
    rel = idx - first;
    cfa_in_win = (idx >= first) && (rel < count);
  endfunction

  function automatic logic cfa_addr_ok(input logic [7:0] a);
    cfa_addr_ok = (a[1:0] == 2'h0) && (a <= `CFA_OFF_IRQ_MASK);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cfa_state_type state;
  logic [`CFA_CW-1:0] frame_total, skip_frames, frames_done, skipped;
  logic [`CFA_CW-1:0] acq_h_first, acq_h_count, acq_v_first, acq_v_count;
  logic [`CFA_CW-1:0] roi_h_first, roi_h_count, roi_v_first, roi_v_count;
  logic [`CFA_NTRIG-1:0] trig_en, trig_fall_sel, trig_dir, trig_pol, trig_level, trig_route;
  logic [`CFA_NCC-1:0] cc_level, cc_route;
  logic [31:0] pg_period, pg_width, pg_cnt;
  logic pg_run, pg_train, pg_level;
  logic [`CFA_NIRQ-1:0] irq_stat, irq_mask, irq_set;
  logic [28:0] link_s1, link_s2;
  logic pix_clk_d, pix_tick, fval_q, lval_q;
  logic s_fval, s_lval, s_dval, fval_rise, fval_fall, lval_rise, lval_fall, act;
  logic [`CFA_CW-1:0] pix_idx, line_idx, cur_pix, cur_line, rel_pix, rel_line;
  logic win_ok, arm_hit, cap_en, fwd, fs_pend, last_frame;
  logic [`CFA_NTRIG-1:0] trig_s1, trig_s2, trig_d, trig_cur, trig_prev, trig_edge;
  logic trig_hit, wr, wr_ok, sw_start, sw_abort, pg_go, pg_stop, done_evt;
  logic [`CFA_NTRIG-1:0] trig_drive;
  logic [31:0] rd_data;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~cfa_addr_ok(paddr);
  assign wr = psel & penable & pwrite;
  assign wr_ok = wr & cfa_addr_ok(paddr);
  assign sw_start = wr_ok & (paddr == `CFA_OFF_CTRL) & pwdata[`CFA_CTRL_START];
  assign sw_abort = wr_ok & (paddr == `CFA_OFF_CTRL) & pwdata[`CFA_CTRL_ABORT];
  assign pg_go = wr_ok & (paddr == `CFA_OFF_PG_CTRL) & pwdata[`CFA_PG_GO];
  assign pg_stop = wr_ok & (paddr == `CFA_OFF_PG_CTRL) & pwdata[`CFA_PG_STOP];

  always_comb
  begin
    rd_data = 32'h0;
    unique case (paddr)
      `CFA_OFF_STATUS: rd_data = {frames_done, skipped[13:0], state};
      `CFA_OFF_FRAMES: rd_data = {16'h0, frame_total};
      `CFA_OFF_SKIP: rd_data = {16'h0, skip_frames};
      `CFA_OFF_ACQ_H: rd_data = {acq_h_count, acq_h_first};
      `CFA_OFF_ACQ_V: rd_data = {acq_v_count, acq_v_first};
      `CFA_OFF_ROI_H: rd_data = {roi_h_count, roi_h_first};
      `CFA_OFF_ROI_V: rd_data = {roi_v_count, roi_v_first};
      `CFA_OFF_TRIG_START: rd_data = {16'h0, trig_fall_sel, trig_en};
      `CFA_OFF_TRIG_DRIVE: rd_data = {trig_route, trig_level, trig_pol, trig_dir};
      `CFA_OFF_CC: rd_data = {24'h0, cc_route, cc_level};
      `CFA_OFF_PG_PERIOD: rd_data = pg_period;
      `CFA_OFF_PG_WIDTH: rd_data = pg_width;
      `CFA_OFF_PG_CTRL: rd_data = {30'h0, pg_train, pg_run};
      `CFA_OFF_IRQ_STAT: rd_data = {29'h0, irq_stat};
      `CFA_OFF_IRQ_MASK: rd_data = {29'h0, irq_mask};
      default: rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel & ~penable)
      prdata <= rd_data;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      frame_total <= 16'h0001;
      skip_frames <= 16'h0;
      acq_h_first <= 16'h0;
      acq_h_count <= `CFA_RST_COUNT;
      acq_v_first <= 16'h0;
      acq_v_count <= `CFA_RST_COUNT;
      roi_h_first <= 16'h0;
      roi_h_count <= `CFA_RST_COUNT;
      roi_v_first <= 16'h0;
      roi_v_count <= `CFA_RST_COUNT;
      trig_en <= 8'h0;
      trig_fall_sel <= 8'h0;
      {trig_route, trig_level, trig_pol, trig_dir} <= 32'h0;
      {cc_route, cc_level} <= 8'h0;
      pg_period <= 32'h0;
      pg_width <= 32'h0;
      irq_mask <= 3'h0;
    end
    else if (wr_ok)
    begin
      unique case (paddr)
        `CFA_OFF_FRAMES: frame_total <= pwdata[15:0];
        `CFA_OFF_SKIP: skip_frames <= pwdata[15:0];
        `CFA_OFF_ACQ_H: {acq_h_count, acq_h_first} <= pwdata;
        `CFA_OFF_ACQ_V: {acq_v_count, acq_v_first} <= pwdata;
        `CFA_OFF_ROI_H: {roi_h_count, roi_h_first} <= pwdata;
        `CFA_OFF_ROI_V: {roi_v_count, roi_v_first} <= pwdata;
        `CFA_OFF_TRIG_START: {trig_fall_sel, trig_en} <= pwdata[15:0];
        `CFA_OFF_TRIG_DRIVE: {trig_route, trig_level, trig_pol, trig_dir} <= pwdata;
        `CFA_OFF_CC: {cc_route, cc_level} <= pwdata[7:0];
        `CFA_OFF_PG_PERIOD: pg_period <= pwdata;
        `CFA_OFF_PG_WIDTH: pg_width <= pwdata;
        `CFA_OFF_IRQ_MASK: irq_mask <= pwdata[2:0];
        default:
        begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Camera link sampling
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      link_s1 <= 29'h0;
      link_s2 <= 29'h0;
      pix_clk_d <= 1'b0;
    end
    else
    begin
      link_s1 <= {cam_pix_clk, cam_spare, cam_dval, cam_lval, cam_fval, cam_data};
      link_s2 <= link_s1;
      pix_clk_d <= link_s2[28];
    end
  end

  assign pix_tick = link_s2[28] & ~pix_clk_d;
  assign s_fval = link_s2[24];
  assign s_lval = link_s2[25];
  assign s_dval = link_s2[26];
  assign act = s_fval & s_lval & s_dval;
  assign fval_rise = s_fval & ~fval_q;
  assign fval_fall = ~s_fval & fval_q;
  assign lval_rise = s_lval & ~lval_q;
  assign lval_fall = ~s_lval & lval_q;
  assign cur_pix = lval_rise ? 16'h0 : pix_idx;
  assign cur_line = fval_rise ? 16'h0 : line_idx;
  assign rel_pix = cur_pix - acq_h_first;
  assign rel_line = cur_line - acq_v_first;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fval_q <= 1'b0;
      lval_q <= 1'b0;
      pix_idx <= 16'h0;
      line_idx <= 16'h0;
    end
    else if (pix_tick)
    begin
      fval_q <= s_fval;
      lval_q <= s_lval;
      if (lval_rise)
        pix_idx <= {15'h0, act};
      else if (act)
        pix_idx <= pix_idx + 16'h1;
      if (fval_rise)
        line_idx <= 16'h0;
      else if (lval_fall)
        line_idx <= line_idx + 16'h1;
    end
  end

  // ----------------------------------------
  // Window and region cropping
  // ----------------------------------------
  assign win_ok = cfa_in_win(cur_pix, acq_h_first, acq_h_count)
                & cfa_in_win(cur_line, acq_v_first, acq_v_count)
                & cfa_in_win(rel_pix, roi_h_first, roi_h_count)
                & cfa_in_win(rel_line, roi_v_first, roi_v_count);
  assign cap_en = (state == cfa_capt) | arm_hit;
  assign fwd = pix_tick & act & win_ok & cap_en;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pix_out_data <= 24'h0;
      pix_out_spare <= 1'b0;
      pix_out_valid <= 1'b0;
      pix_out_frame_start <= 1'b0;
      fs_pend <= 1'b0;
    end
    else
    begin
      pix_out_valid <= fwd;
      pix_out_frame_start <= fwd & (fs_pend | (pix_tick & fval_rise));
      if (fwd)
      begin
        pix_out_data <= link_s2[23:0];
        pix_out_spare <= link_s2[27];
      end
      if (fwd)
        fs_pend <= 1'b0;
      else if (pix_tick & fval_rise & cap_en)
        fs_pend <= 1'b1;
    end
  end

  // ----------------------------------------
  // Trigger inputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_s1 <= 8'h0;
      trig_s2 <= 8'h0;
      trig_d <= 8'h0;
    end
    else
    begin
      trig_s1 <= {backplane_trigger_bus_in, front_trigger_lines_in};
      trig_s2 <= trig_s1;
      trig_d <= trig_s2;
    end
  end

  assign trig_cur = trig_s2 ^ trig_pol;
  assign trig_prev = trig_d ^ trig_pol;
  assign trig_edge = trig_fall_sel & trig_prev & ~trig_cur
                   | ~trig_fall_sel & trig_cur & ~trig_prev;
  assign trig_hit = |(trig_en & ~trig_dir & trig_edge);

  // ----------------------------------------
  // Acquisition control
  // ----------------------------------------
  assign arm_hit = (state == cfa_arm) & pix_tick & fval_rise & (skipped == skip_frames);
  assign last_frame = (frame_total != 16'h0) & (16'(frames_done + 16'h1) == frame_total);
  assign done_evt = (state == cfa_capt) & ~sw_abort & pix_tick & fval_fall & last_frame;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= cfa_idle;
      skipped <= 16'h0;
      frames_done <= 16'h0;
    end
    else
    begin
      unique case (state)
        cfa_idle:
          if (sw_start | trig_hit)
          begin
            state <= cfa_arm;
            skipped <= 16'h0;
          end
        cfa_arm:
          if (sw_abort)
            state <= cfa_idle;
          else if (arm_hit)
          begin
            state <= cfa_capt;
            frames_done <= 16'h0;
          end
          else if (pix_tick & fval_rise)
            skipped <= skipped + 16'h1;
        cfa_capt:
          if (sw_abort)
            state <= cfa_idle;
          else if (pix_tick & fval_fall)
          begin
            frames_done <= frames_done + 16'h1;
            if (last_frame)
              state <= cfa_idle;
          end
      endcase
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  assign irq_set = {(state == cfa_capt) & pix_tick & fval_fall, arm_hit, done_evt};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= 3'h0;
      acq_done <= 1'b0;
      irq <= 1'b0;
    end
    else
    begin
      if (wr_ok & (paddr == `CFA_OFF_IRQ_STAT))
        irq_stat <= (irq_stat & ~pwdata[2:0]) | irq_set;
      else
        irq_stat <= irq_stat | irq_set;
      acq_done <= done_evt;
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------
  // Pulse generator
  // ----------------------------------------
  assign pg_level = pg_run & (pg_cnt < pg_width);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pg_run <= 1'b0;
      pg_train <= 1'b0;
      pg_cnt <= 32'h0;
    end
    else if (pg_stop)
      pg_run <= 1'b0;
    else if (pg_go)
    begin
      pg_run <= 1'b1;
      pg_train <= pwdata[`CFA_PG_TRAIN];
      pg_cnt <= 32'h0;
    end
    else if (pg_run)
    begin
      if (pg_cnt >= 32'(pg_period - 32'h1))
      begin
        pg_cnt <= 32'h0;
        pg_run <= pg_train;
      end
      else
        pg_cnt <= pg_cnt + 32'h1;
    end
  end

  // ----------------------------------------
  // Trigger and camera control outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_drive <= 8'h0;
      camera_control_outputs <= 4'h0;
    end
    else
    begin
      trig_drive <= ((trig_route & {8{pg_level}}) | (~trig_route & trig_level)) ^ trig_pol;
      camera_control_outputs <= (cc_route & {4{pg_level}}) | (~cc_route & cc_level);
    end
  end

  assign front_trigger_lines_out = trig_drive[3:0];
  assign front_trigger_lines_oe = trig_dir[3:0];
  assign backplane_trigger_bus_out = trig_drive[7:4];
  assign backplane_trigger_bus_oe = trig_dir[7:4];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_only_active: assert property (pix_out_valid |-> $past(pix_tick && act))
    else $error("Forwarded pixel without all enables");
  chk_h_window: assert property (pix_out_valid |-> $past(cur_pix >= acq_h_first))
    else $error("Pixel before horizontal window");
  chk_v_window: assert property (pix_out_valid |-> $past(cur_line >= acq_v_first))
    else $error("Line before vertical window");
  chk_roi_crop: assert property (pix_out_valid |-> $past(rel_pix >= roi_h_first
                                 && rel_line >= roi_v_first))
    else $error("Pixel outside region of interest");
  chk_drop_idle: assert property (state == cfa_idle && !arm_hit |=> !pix_out_valid)
    else $error("Pixel forwarded while idle");
  chk_sw_start: assert property (state == cfa_idle && sw_start |=> state == cfa_arm)
    else $error("Software start not taken");
  chk_trig_start: assert property (state == cfa_idle && trig_hit |=> state == cfa_arm)
    else $error("Trigger start not taken");
  chk_skip_hold: assert property (state == cfa_arm && pix_tick && fval_rise
                                  && skipped != skip_frames && !sw_abort
                                  |=> state == cfa_arm && skipped == $past(skipped) + 16'h1)
    else $error("Frame skip miscounted");
  chk_pulse_wrap: assert property (pg_run && pg_train && !pg_stop && !pg_go
                                   && pg_cnt == pg_period - 32'h1 |=> pg_run && pg_cnt == 32'h0)
    else $error("Pulse train did not wrap");
  chk_cc_follow: assert property (cc_route[0] && $rose(pg_level) |=> camera_control_outputs[0])
    else $error("Camera control missed pulse");
  chk_trig_out: assert property (trig_route[0] && !trig_pol[0] && $rose(pg_level)
                                 |=> front_trigger_lines_out[0])
    else $error("Trigger line missed pulse");
  chk_done_stop: assert property (done_evt |=> state == cfa_idle && acq_done
                                  && irq_stat[`CFA_IRQ_DONE])
    else $error("Completion not raised");

endmodule

// file: src/cfa_defs.svh
`ifndef CFA_DEFS_SVH
`define CFA_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CFA_OFF_CTRL 8'h00
`define CFA_OFF_STATUS 8'h04
`define CFA_OFF_FRAMES 8'h08
`define CFA_OFF_SKIP 8'h0c
`define CFA_OFF_ACQ_H 8'h10
`define CFA_OFF_ACQ_V 8'h14
`define CFA_OFF_ROI_H 8'h18
`define CFA_OFF_ROI_V 8'h1c
`define CFA_OFF_TRIG_START 8'h20
`define CFA_OFF_TRIG_DRIVE 8'h24
`define CFA_OFF_CC 8'h28
`define CFA_OFF_PG_PERIOD 8'h2c
`define CFA_OFF_PG_WIDTH 8'h30
`define CFA_OFF_PG_CTRL 8'h34
`define CFA_OFF_IRQ_STAT 8'h38
`define CFA_OFF_IRQ_MASK 8'h3c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFA_CTRL_START 0
`define CFA_CTRL_ABORT 1
`define CFA_PG_GO 0
`define CFA_PG_TRAIN 1
`define CFA_PG_STOP 2
`define CFA_IRQ_DONE 0
`define CFA_IRQ_START 1
`define CFA_IRQ_FRAME 2

// ----------------------------------------
// Widths and reset values
// ----------------------------------------
`define CFA_NTRIG 8
`define CFA_NCC 4
`define CFA_DW 24
`define CFA_CW 16
`define CFA_NIRQ 3
`define CFA_RST_COUNT 16'hffff

`endif

// file: src/cfa_pkg.sv
package cfa_pkg;

  // ----------------------------------------
  // Acquisition states
  // ----------------------------------------
  typedef enum logic [1:0] {cfa_idle, cfa_arm, cfa_capt} cfa_state_type;

endpackage

// file: dv/cfa_camera_model.sv
`timescale 1ns/1ps
module cfa_camera_model (
  output logic pix_clk,
  output logic [23:0] data,
  output logic fval,
  output logic lval,
  output logic dval,
  output logic spare
);
  // ----------------------------------------
  // Camera lanes
  // ----------------------------------------
  initial
  begin
    pix_clk = 1'b0;
    {data, fval, lval, dval, spare} = '0;
  end

  // One pixel clock; lanes change while the clock is low
  task automatic tick(input logic f, input logic l, input logic d, input logic [23:0] v);
    fval = f;
    lval = l;
    dval = d;
    data = d ? v : ~data;
    spare = d ? v[0] : ~spare;
    #80 pix_clk = 1'b1;
    #80 pix_clk = 1'b0;
  endtask

  // Frame of nl lines; clock stands still afterwards
  task automatic send_frame(input int np, input int nl);
    tick(1'b1, 1'b0, 1'b0, 24'h0);
    for (int l = 0; l < nl; l++)
    begin
      tick(1'b1, 1'b1, 1'b0, 24'h0);
      for (int p = 0; p < np; p++)
        tick(1'b1, 1'b1, 1'b1, {8'h00, 8'(l), 8'(p)});
      tick(1'b1, 1'b0, 1'b0, 24'h0);
    end
    tick(1'b0, 1'b0, 1'b0, 24'h0);
    #400;
  endtask
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ps
`include "cfa_defs.svh"
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic cam_pix_clk, cam_fval, cam_lval, cam_dval, cam_spare;
  logic [23:0] cam_data, pix_out_data;
  logic [3:0] front_trigger_lines_in, front_trigger_lines_out, front_trigger_lines_oe;
  logic [3:0] backplane_trigger_bus_in, backplane_trigger_bus_out, backplane_trigger_bus_oe;
  logic [3:0] camera_control_outputs;
  logic pix_out_spare, pix_out_valid, pix_out_frame_start, acq_done, irq, err_seen;
  logic [7:0] trig_pins;
  logic [23:0] got[$];
  logic got_sp[$];
  int err_count = 0;
  int total_checks = 0;
  int n_fs, n_done, hi_cc, hi_tr;

  always #5 pclk = ~pclk;

  // Wire level from design drive or bench drive
  assign front_trigger_lines_in = (front_trigger_lines_oe & front_trigger_lines_out)
    | (~front_trigger_lines_oe & trig_pins[3:0]);
  assign backplane_trigger_bus_in = (backplane_trigger_bus_oe & backplane_trigger_bus_out)
    | (~backplane_trigger_bus_oe & trig_pins[7:4]);

  cfa_top u_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
    .prdata, .pslverr, .cam_pix_clk, .cam_data, .cam_fval, .cam_lval, .cam_dval,
    .cam_spare, .front_trigger_lines_in, .front_trigger_lines_out, .front_trigger_lines_oe,
    .backplane_trigger_bus_in, .backplane_trigger_bus_out, .backplane_trigger_bus_oe,
    .camera_control_outputs, .pix_out_data, .pix_out_spare, .pix_out_valid,
    .pix_out_frame_start, .acq_done, .irq);

  cfa_camera_model u_cam (.pix_clk(cam_pix_clk), .data(cam_data), .fval(cam_fval),
    .lval(cam_lval), .dval(cam_dval), .spare(cam_spare));

  // ----------------------------------------
  // Output monitor
  // ----------------------------------------
  always @(posedge pclk)
  begin
    if (pix_out_valid === 1'b1)
    begin
      got.push_back(pix_out_data);
      got_sp.push_back(pix_out_spare);
    end
    if (pix_out_frame_start === 1'b1)
      n_fs++;
    if (acq_done === 1'b1)
      n_done++;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      err_count++;
      test_done();
    end
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0);
  endtask

  // Align to first pulse, then count high cycles
  task automatic count_hi(input int cyc);
    int n;
    n = 0;
    while (camera_control_outputs[0] !== 1'b1 && n < 50)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50)
    begin
      err_count++;
      test_done();
    end
    hi_cc = 0;
    hi_tr = 0;
    repeat (cyc)
    begin
      hi_cc += int'(camera_control_outputs[0] === 1'b1);
      hi_tr += int'(front_trigger_lines_out[0] === 1'b1);
      @(posedge pclk);
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {presetn, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    trig_pins = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`CFA_OFF_FRAMES);
    check(r, 32'h1);
    rd(`CFA_OFF_ACQ_H);
    check(r, 32'hffff_0000);
    rd(`CFA_OFF_ROI_V);
    check(r, 32'hffff_0000);
    rd(8'h40);
    check({r[30:0], err_seen}, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 8; i++)
    begin
      wr(`CFA_OFF_TRIG_START, 32'h0);
      trig_pins[i] <= 1'(i % 2);
      repeat (5) @(posedge pclk);
      wr(`CFA_OFF_TRIG_START, (32'h1 << i) | (32'(i % 2) << (i + 8)));
      trig_pins[i] <= 1'(~(i % 2));
      repeat (6) @(posedge pclk);
      rd(`CFA_OFF_STATUS);
      check(32'(r[1:0]), 32'h1);
      wr(`CFA_OFF_CTRL, 32'h2);
      trig_pins[i] <= 1'b0;
    end
    wr(`CFA_OFF_TRIG_START, 32'h0);
    $display("test triggers done");
    wr(`CFA_OFF_TRIG_DRIVE, 32'h0011_0011);
    wr(`CFA_OFF_CC, 32'h0000_000a);
    repeat (3) @(posedge pclk);
    check({front_trigger_lines_oe, front_trigger_lines_out, backplane_trigger_bus_oe,
      backplane_trigger_bus_out, 12'h0, camera_control_outputs}, 32'h1111_000a);
    wr(`CFA_OFF_TRIG_DRIVE, 32'h0011_0111);
    repeat (3) @(posedge pclk);
    check(32'(front_trigger_lines_out), 32'h0);
    wr(`CFA_OFF_TRIG_DRIVE, 32'h0100_0001);
    wr(`CFA_OFF_CC, 32'h10);
    wr(`CFA_OFF_PG_PERIOD, 32'h5);
    wr(`CFA_OFF_PG_WIDTH, 32'h2);
    wr(`CFA_OFF_PG_CTRL, 32'h3);
    count_hi(20);
    check(32'({hi_cc[7:0], hi_tr[7:0]}), 32'h0808);
    wr(`CFA_OFF_PG_CTRL, 32'h4);
    repeat (5) @(posedge pclk);
    rd(`CFA_OFF_PG_CTRL);
    check(32'(r[0]), 32'h0);
    wr(`CFA_OFF_PG_CTRL, 32'h1);
    count_hi(30);
    check(32'(hi_cc), 32'h2);
    $display("test outputs done");
    wr(`CFA_OFF_ACQ_H, 32'h0004_0001);
    wr(`CFA_OFF_ACQ_V, 32'h0002_0001);
    wr(`CFA_OFF_ROI_H, 32'h0005_0002);
    wr(`CFA_OFF_ROI_V, 32'h0009_0001);
    {n_fs, n_done} = '0;
    wr(`CFA_OFF_CTRL, 32'h1);
    repeat (2) u_cam.send_frame(6, 4);
    check(32'(got.size()), 32'h2);
    check({got[0], got[1][7:0]}, 32'h0002_0304);
    check(32'({n_fs[7:0], n_done[7:0]}), 32'h0101);
    $display("test single frame done");
    got.delete();
    got_sp.delete();
    {n_fs, n_done} = '0;
    wr(`CFA_OFF_IRQ_STAT, 32'h7);
    wr(`CFA_OFF_IRQ_MASK, 32'h1);
    wr(`CFA_OFF_FRAMES, 32'h2);
    wr(`CFA_OFF_SKIP, 32'h1);
    check(32'(irq), 32'h0);
    wr(`CFA_OFF_CTRL, 32'h1);
    repeat (4) u_cam.send_frame(6, 4);
    check(32'(got.size()), 32'h4);
    foreach (got[k])
    begin
      check(32'(got[k]), 32'h0203 + 32'(k % 2));
      check(32'(got_sp[k]), 32'((k + 1) % 2));
    end
    check(32'({n_fs[7:0], n_done[7:0], 7'h0, irq}), 32'h0002_0101);
    rd(`CFA_OFF_STATUS);
    check(32'(r[1:0]), 32'h0);
    wr(`CFA_OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge pclk);
    check(32'(irq), 32'h0);
    $display("test skip and count done");
    test_done();
  end
endmodule
